// ---- design/sip_policy_regs.sv ----
// Ingress policy register bank of the switch engine with its APB slave.
module sip_policy_regs
	import sip_pkg::*;
#(
	parameter int unsigned THR_INTERVAL_CYCLES = THR_INTERVAL_CYC,
	parameter int unsigned OP_CYCLES           = 2
) (
	// Clock and reset.
	input  wire logic                                   clk_sys,
	input  wire logic                                   rst,
	// APB slave.
	input  wire logic [15:0]                            paddr,
	input  wire logic                                   psel,
	input  wire logic                                   penable,
	input  wire logic                                   pwrite,
	input  wire logic [31:0]                            pwdata,
	input  wire logic [3:0]                             pstrb,
	output logic [31:0]                                 prdata,
	output logic                                        pready,
	output logic                                        pslverr,
	// Forwarding and admission controls.
	output logic [NUM_PORTS-1:0]                        tagDestEnable,
	output logic [NUM_PORTS-1:0]                        admitNonMember,
	// Broadcast throttling.
	output logic [NUM_PORTS-1:0]                        bcastThrottleEnable,
	output logic [NUM_PORTS-1:0][THR_BUDGET_W-1:0]      bcastByteBudget,
	output logic                                        bcastIntervalTick,
	// Metering key and results.
	input  wire logic [1:0]                             meterPort,
	input  wire logic [2:0]                             meterPriority,
	output logic                                        meterEnable,
	output sip_mode_t                                   meterMode,
	output logic                                        meterValid,
	output logic [BYTE_TIME_W-1:0]                      meterByteTimeNs,
	output logic [TBL_W-1:0]                            committedBurst,
	output logic [TBL_W-1:0]                            excessBurst
);
	// Byte addresses of the registers.
	localparam logic [15:0] ADDR_TAG_DEST   = 16'(IDX_TAG_DEST << 2);
	localparam logic [15:0] ADDR_THROTTLE   = 16'(IDX_THROTTLE << 2);
	localparam logic [15:0] ADDR_ADMIT      = 16'(IDX_ADMIT << 2);
	localparam logic [15:0] ADDR_METER_CFG  = 16'(IDX_METER_CFG << 2);
	localparam logic [15:0] ADDR_METER_CMD  = 16'(IDX_METER_CMD << 2);
	localparam logic [15:0] ADDR_CMD_STATUS = 16'(IDX_CMD_STATUS << 2);
	localparam logic [15:0] ADDR_WRITE_VAL  = 16'(IDX_WRITE_VAL << 2);
	localparam logic [15:0] ADDR_READ_VAL   = 16'(IDX_READ_VAL << 2);
	localparam int unsigned CNT_W = $clog2(THR_INTERVAL_CYCLES);
	// Bound on the wait for a command to finish, for checking only.
	localparam int A_OP_MAX = 8;

	// Merges the written bytes that the strobes select into a word.
	function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
		input logic [31:0] newVal, input logic [3:0] strb);
		logic [31:0] res;
		res = oldVal;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = newVal[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Byte time of a committed rate entry.
	function automatic logic [BYTE_TIME_W-1:0] byteTimeOf(
		input logic [TBL_W-1:0] rate);
		return (BYTE_TIME_W'(rate) + BYTE_TIME_W'(1)) *
			BYTE_TIME_W'(CIR_STEP_NS);
	endfunction

	// Table entry for a port and priority under a rate mode.
	function automatic logic [CMD_ADDR_W-1:0] entryFor(input sip_mode_t mode,
		input logic [1:0] port, input logic [2:0] prio);
		logic [CMD_ADDR_W-1:0] e;
		e = '0;
		unique case (mode)
			MODE_PORT_PRIO: e = {port, prio};
			MODE_PORT:      e = CMD_ADDR_W'(port);
			MODE_PRIO:      e = CMD_ADDR_W'(prio);
			MODE_RSVD:      e = '0;
		endcase
		return e;
	endfunction

	// Software-visible storage.
	logic [TAG_W*NUM_PORTS-1:0] tagSelect;   // Ingress tag destination select.
	logic [THR_W-1:0]           throttleCfg; // Broadcast throttle control.
	logic [NUM_PORTS-1:0]       admitSel;    // Admit non-member control.
	logic [2:0]                 meterCfg;    // Meter mode and enable.
	logic [7:0]                 meterCmd;    // Last accepted command.
	logic [TBL_W-1:0]           writeValue;  // Table write value.
	// Internal state.
	logic [CNT_W-1:0]           intervalCnt; // Throttle interval timer.
	logic                       lookupValid; // Key valid, first stage.
	// Reads have no side effects, so capturing them early is safe.
	logic [31:0]                readMuxReg;

	sip_table_if tbl ();

	// Bus decode.
	wire        setupRead  = psel && !penable && !pwrite;
	wire        accessWr   = psel && penable && pwrite;
	wire        hitTag     = (paddr == ADDR_TAG_DEST);
	wire        hitThr     = (paddr == ADDR_THROTTLE);
	wire        hitAdmit   = (paddr == ADDR_ADMIT);
	wire        hitCfg     = (paddr == ADDR_METER_CFG);
	wire        hitCmd     = (paddr == ADDR_METER_CMD);
	wire        hitStatus  = (paddr == ADDR_CMD_STATUS);
	wire        hitWrVal   = (paddr == ADDR_WRITE_VAL);
	wire        hitRdVal   = (paddr == ADDR_READ_VAL);
	wire        mapped     = hitTag | hitThr | hitAdmit | hitCfg | hitCmd |
		hitStatus | hitWrVal | hitRdVal;
	// A command written while one is running is dropped whole.
	// Pending is registered state, so this gate forms no feedback loop.
	wire        cmdAccept  = accessWr && hitCmd && !tbl.pending;
	wire [31:0] cmdMerged  = mergeBytes({24'h000000, meterCmd}, pwdata, pstrb);
	wire [31:0] readMux;

	// The slave never waits; unmapped addresses answer with an error.
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Read data selection; reserved bits read as zero.
	assign readMux = hitTag    ? 32'(tagSelect) :
		hitThr    ? 32'(throttleCfg) :
		hitAdmit  ? 32'(admitSel) :
		hitCfg    ? 32'(meterCfg) :
		hitCmd    ? 32'(meterCmd) :
		hitStatus ? 32'(tbl.pending) :
		hitWrVal  ? 32'(writeValue) :
		hitRdVal  ? 32'(tbl.readValue) : 32'h00000000;

	// Command fields go straight to the table from the accepted write.
	assign tbl.start = cmdAccept;
	assign tbl.readNotWrite = cmdMerged[CMD_RNW_BIT];
	assign tbl.target = sip_tbl_t'(cmdMerged[CMD_TYPE_LSB +: 2]);
	assign tbl.entry = cmdMerged[CMD_ADDR_W-1:0];
	assign tbl.writeValue = writeValue;
	assign tbl.lookupEntry = entryFor(meterMode, meterPort, meterPriority);

	// Decoded controls, all taken from the flip-flops above.
	assign meterEnable = meterCfg[CFG_EN_BIT];
	assign meterMode = sip_mode_t'(meterCfg[CFG_MODE_LSB +: 2]);
	assign committedBurst = tbl.committedBurst;
	assign excessBurst = tbl.excessBurst;
	assign prdata = readMuxReg;
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		assign tagDestEnable[p] =
			(tagSelect[p*TAG_W +: TAG_W] == TAG_DEST_ON);
		assign bcastThrottleEnable[p] =
			throttleCfg[p*THR_STRIDE + THR_LVL_W];
		assign bcastByteBudget[p] = THR_BUDGET_W'(
			throttleCfg[p*THR_STRIDE +: THR_LVL_W] * THR_BYTE_UNIT);
		assign admitNonMember[p] = admitSel[p];
	end

	// Table store and command sequencer.
	sip_meter_table #(
		.OP_CYCLES (OP_CYCLES)
	) u_table (
		.clk_sys (clk_sys),
		.rst     (rst),
		.tbl     (tbl.store)
	);

	// Register writes take effect at the edge that ends the access phase.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tagSelect <= TAG_RST;
			throttleCfg <= THR_RST;
			admitSel <= ADMIT_RST;
			meterCfg <= CFG_RST;
			writeValue <= '0;
		end else if (accessWr) begin
			// Each cast keeps the implemented bits; reserved ones fall away.
			if (hitTag) begin
				tagSelect <= (TAG_W*NUM_PORTS)'(mergeBytes(
					32'(tagSelect), pwdata, pstrb));
			end
			if (hitThr) begin
				throttleCfg <= THR_W'(mergeBytes(32'(throttleCfg), pwdata,
					pstrb));
			end
			if (hitAdmit) begin
				admitSel <= NUM_PORTS'(mergeBytes(32'(admitSel), pwdata,
					pstrb));
			end
			if (hitCfg) begin
				meterCfg <= 3'(mergeBytes(32'(meterCfg), pwdata, pstrb));
			end
			if (hitWrVal) begin
				writeValue <= TBL_W'(mergeBytes(32'(writeValue), pwdata,
					pstrb));
			end
		end
	end

	// The command register keeps only what was accepted.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meterCmd <= CMD_RST;
		end else if (cmdAccept) begin
			meterCmd <= cmdMerged[7:0];
		end
	end

	// Read data is captured in the setup cycle, ready for the access.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			readMuxReg <= '0;
		end else if (setupRead) begin
			readMuxReg <= readMux;
		end
	end

	// Throttle interval timer; one tick opens each new budget window.
	// The first tick comes a full interval after reset; a level change reaches
	// bcastByteBudget at the edge that ends its write, not at a tick.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			intervalCnt <= '0;
			bcastIntervalTick <= 1'b0;
		end else begin
			bcastIntervalTick <=
				(intervalCnt == CNT_W'(THR_INTERVAL_CYCLES - 1));
			intervalCnt <= (intervalCnt == CNT_W'(THR_INTERVAL_CYCLES - 1)) ?
				'0 : intervalCnt + CNT_W'(1);
		end
	end

	// Metering result pipeline, aligned with the table lookup stage.
	// A reserved mode or a disabled meter yields no valid result.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lookupValid <= 1'b0;
			meterValid <= 1'b0;
			meterByteTimeNs <= '0;
		end else begin
			lookupValid <= meterEnable && (meterMode != MODE_RSVD) &&
				(tbl.lookupEntry < CIR_COUNT);
			meterValid <= lookupValid;
			meterByteTimeNs <= byteTimeOf(tbl.lookupCir);
		end
	end

	// A full APB write to one register, byte lane zero included.
	sequence s_write_low(logic [15:0] addr);
		psel && penable && pwrite && (paddr == addr) && pstrb[0];
	endsequence

	// The single cycle in which a command write is accepted.
	sequence s_cmd_launch;
		accessWr && hitCmd && !tbl.pending;
	endsequence

	a_tag_dest_on: assert property (@(posedge clk_sys) disable iff (rst)
		s_write_low(ADDR_TAG_DEST) ##0 (pwdata[1:0] == TAG_DEST_ON)
		|=> tagDestEnable[0])
		else $error("Port 0 tag destination not enabled by 11b.");

	a_throttle_enable: assert property (@(posedge clk_sys)
		disable iff (rst)
		(accessWr && hitThr && pstrb[3]) |=>
		(bcastThrottleEnable[2] == $past(pwdata[26])))
		else $error("Port 2 throttle enable did not follow bit 26.");

	a_throttle_budget: assert property (@(posedge clk_sys)
		disable iff (rst)
		s_write_low(ADDR_THROTTLE) |=>
		(bcastByteBudget[0] == {$past(pwdata[7:0]), 6'h00}))
		else $error("Port 0 byte budget is not level times 64.");

	a_admit_write: assert property (@(posedge clk_sys)
		disable iff (rst)
		s_write_low(ADDR_ADMIT) |=> (admitNonMember == $past(pwdata[2:0])))
		else $error("Admit non-member bits did not follow the write.");

	a_meter_gated: assert property (@(posedge clk_sys)
		disable iff (rst)
		(!meterEnable || meterMode == MODE_RSVD) ##1 1'b1 |=> !meterValid)
		else $error("Meter result valid while metering is off.");

	a_key_mapping: assert property (@(posedge clk_sys)
		disable iff (rst)
		((meterMode == MODE_PORT_PRIO) |->
			(tbl.lookupEntry == 5'(meterPort) * 5'h08 + 5'(meterPriority))) and
		((meterMode == MODE_PORT) |-> (tbl.lookupEntry == 5'(meterPort))) and
		((meterMode == MODE_PRIO) |-> (tbl.lookupEntry == 5'(meterPriority))))
		else $error("Meter key does not match the rate mode.");

	a_pending_rises: assert property (@(posedge clk_sys)
		disable iff (rst)
		s_cmd_launch |=> tbl.pending)
		else $error("Pending not set from the command accept cycle.");

	a_pending_clears: assert property (@(posedge clk_sys)
		disable iff (rst)
		s_cmd_launch |=> ##[0:A_OP_MAX] !tbl.pending)
		else $error("Pending did not clear after a table command.");

	a_byte_time: assert property (@(posedge clk_sys)
		disable iff (rst)
		meterValid |-> (meterByteTimeNs ==
			(21'($past(tbl.lookupCir)) + 21'h000001) * 21'h000014))
		else $error("Byte time is not (entry plus one) times 20 ns.");

	a_cmd_dropped: assert property (@(posedge clk_sys)
		disable iff (rst)
		(accessWr && hitCmd && tbl.pending) |=> $stable(meterCmd))
		else $error("Command written while pending was not dropped.");

	a_tick_single: assert property (@(posedge clk_sys)
		disable iff (rst)
		bcastIntervalTick |=> !bcastIntervalTick)
		else $error("Interval tick lasted more than one cycle.");

	a_status_readout: assert property (@(posedge clk_sys)
		disable iff (rst)
		(setupRead && hitStatus) |=>
		(prdata == 32'($past(tbl.pending))))
		else $error("Status read does not show the pending flag.");
endmodule // sip_policy_regs

// ---- design/sip_pkg.sv ----
// Shared constants and types for the switch ingress policy register bank.
package sip_pkg;
	// Number of switch ports served by the block.
	localparam int unsigned NUM_PORTS = 3;
	// Register indices; the byte address is four times the index.
	localparam logic [15:0] IDX_TAG_DEST   = 16'h1847;
	localparam logic [15:0] IDX_THROTTLE   = 16'h1848;
	localparam logic [15:0] IDX_ADMIT      = 16'h1849;
	localparam logic [15:0] IDX_METER_CFG  = 16'h184A;
	localparam logic [15:0] IDX_METER_CMD  = 16'h184B;
	localparam logic [15:0] IDX_CMD_STATUS = 16'h184C;
	localparam logic [15:0] IDX_WRITE_VAL  = 16'h184D;
	localparam logic [15:0] IDX_READ_VAL   = 16'h184E;
	// Ingress tag destination select fields, two bits per port.
	localparam int unsigned TAG_W        = 2;
	localparam logic [1:0]  TAG_DEST_ON  = 2'h3;
	localparam logic [5:0]  TAG_RST      = 6'h00;
	// Broadcast throttle layout: nine bits per port, enable above level.
	localparam int unsigned THR_STRIDE   = 9;
	localparam int unsigned THR_LVL_W    = 8;
	localparam int unsigned THR_W        = 27;
	localparam logic [26:0] THR_RST      = 27'h0080402;
	localparam int unsigned THR_BYTE_UNIT = 64;
	localparam int unsigned THR_BUDGET_W = 14;
	// Throttle interval of 1.72 ms, held in microseconds.
	localparam int unsigned THR_INTERVAL_US = 1720;
	localparam int unsigned CLK_PERIOD_NS   = 8;
	localparam int unsigned THR_INTERVAL_CYC =
		(THR_INTERVAL_US * 1000) / CLK_PERIOD_NS;
	// Admit non-member and meter configuration fields.
	localparam logic [2:0]  ADMIT_RST    = 3'h0;
	localparam int unsigned CFG_EN_BIT   = 0;
	localparam int unsigned CFG_MODE_LSB = 1;
	localparam logic [2:0]  CFG_RST      = 3'h0;
	// Meter command fields.
	localparam int unsigned CMD_RNW_BIT  = 7;
	localparam int unsigned CMD_TYPE_LSB = 5;
	localparam int unsigned CMD_ADDR_W   = 5;
	localparam logic [7:0]  CMD_RST      = 8'h00;
	// Metering table geometry and reset contents.
	localparam int unsigned TBL_W        = 16;
	localparam int unsigned CIR_ENTRIES  = 24;
	localparam logic [4:0]  CIR_COUNT    = 5'h18;
	localparam logic [15:0] CIR_RST      = 16'h0014;
	localparam logic [15:0] BURST_RST    = 16'h0600;
	localparam int unsigned CIR_STEP_NS  = 20;
	localparam int unsigned BYTE_TIME_W  = 21;
	// Metering key selection.
	typedef enum logic [1:0] {
		MODE_PORT_PRIO = 2'b00,
		MODE_PORT      = 2'b01,
		MODE_PRIO      = 2'b10,
		MODE_RSVD      = 2'b11
	} sip_mode_t;
	// Table access target.
	typedef enum logic [1:0] {
		TBL_RSVD = 2'b00,
		TBL_CIR  = 2'b01,
		TBL_CBS  = 2'b10,
		TBL_EBS  = 2'b11
	} sip_tbl_t;
	// Table sequencer state.
	typedef enum logic {
		OP_IDLE = 1'b0,
		OP_BUSY = 1'b1
	} sip_op_state_t;
endpackage

// ---- design/sip_table_if.sv ----
// Link between the register bank and the metering table store.
interface sip_table_if;
	import sip_pkg::*;
	logic                  start;          // One-cycle command launch.
	logic                  readNotWrite;   // High for a table read.
	sip_tbl_t              target;         // Table selected by the command.
	logic [CMD_ADDR_W-1:0] entry;          // Rate entry address.
	logic [TBL_W-1:0]      writeValue;     // Value for a table write.
	logic                  pending;        // Command in progress.
	logic [TBL_W-1:0]      readValue;      // Result of the last read.
	logic [CMD_ADDR_W-1:0] lookupEntry;    // Entry the meter needs now.
	logic [TBL_W-1:0]      lookupCir;      // Entry contents, one cycle later.
	logic [TBL_W-1:0]      committedBurst; // Committed burst size.
	logic [TBL_W-1:0]      excessBurst;    // Excess burst size.
	modport ctrl (output start, readNotWrite, target, entry, writeValue,
		lookupEntry, input pending, readValue, lookupCir, committedBurst,
		excessBurst);
	modport store (input start, readNotWrite, target, entry, writeValue,
		lookupEntry, output pending, readValue, lookupCir, committedBurst,
		excessBurst);
endinterface

// ---- design/sip_meter_table.sv ----
// Metering and colour table with its command sequencer.
module sip_meter_table
	import sip_pkg::*;
#(
	parameter int unsigned OP_CYCLES = 2
) (
	// Clock and reset.
	input  wire logic  clk_sys,
	input  wire logic  rst,
	// Command and lookup side.
	sip_table_if.store tbl
);
	localparam int unsigned OPW = $clog2(OP_CYCLES + 1);

	sip_op_state_t         opState;  // Sequencer state.
	logic [OPW-1:0]        opCnt;    // Cycles left in the running command.
	logic                  opRead;   // Latched direction.
	sip_tbl_t              opTarget; // Latched target.
	logic [CMD_ADDR_W-1:0] opEntry;  // Latched entry address.
	logic [TBL_W-1:0]      opValue;  // Latched write value.
	logic [TBL_W-1:0]      cir [CIR_ENTRIES]; // Committed rate entries.
	logic [TBL_W-1:0]      cbs;      // Committed burst size.
	logic [TBL_W-1:0]      ebs;      // Excess burst size.
	logic [TBL_W-1:0]      readValue;
	logic [TBL_W-1:0]      lookupCir;
	wire                   opDone;
	wire                   cirHit;
	wire  [TBL_W-1:0]      tableRead;

	// Last cycle of a command; the access lands here.
	assign opDone = (opState == OP_BUSY) && (opCnt == '0);
	// Out-of-range entries are neither written nor read back.
	assign cirHit = (opTarget == TBL_CIR) && (opEntry < CIR_COUNT);
	assign tableRead = (opTarget == TBL_CIR) ? (cirHit ? cir[opEntry] : '0) :
		(opTarget == TBL_CBS) ? cbs :
		(opTarget == TBL_EBS) ? ebs : '0;
	// Pending is the busy state alone. The edge that accepts a command
	// sets it, so a poll that follows never sees a false finish, and it
	// reaches the accept gate of the register bank only as registered state.
	assign tbl.pending = (opState == OP_BUSY);
	assign tbl.readValue = readValue;
	assign tbl.lookupCir = lookupCir;
	assign tbl.committedBurst = cbs;
	assign tbl.excessBurst = ebs;

	// Sequencer: latch the command, count it out, then return to idle.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			opState <= OP_IDLE;
			opCnt <= '0;
			opRead <= 1'b0;
			opTarget <= TBL_RSVD;
			opEntry <= '0;
			opValue <= '0;
		end else begin
			unique case (opState)
				OP_IDLE: begin
					if (tbl.start) begin
						opState <= OP_BUSY;
						opCnt <= OPW'(OP_CYCLES - 1);
						opRead <= tbl.readNotWrite;
						opTarget <= tbl.target;
						opEntry <= tbl.entry;
						opValue <= tbl.writeValue;
					end
				end
				OP_BUSY: begin
					if (opDone) begin
						opState <= OP_IDLE;
					end else begin
						opCnt <= opCnt - OPW'(1);
					end
				end
			endcase
		end
	end

	// Table storage, 16 bits per entry, written at command completion.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < CIR_ENTRIES; i++) begin
				cir[i] <= CIR_RST;
			end
			cbs <= BURST_RST;
			ebs <= BURST_RST;
		end else if (opDone && !opRead) begin
			if (cirHit) begin
				cir[opEntry] <= opValue;
			end
			if (opTarget == TBL_CBS) begin
				cbs <= opValue;
			end
			if (opTarget == TBL_EBS) begin
				ebs <= opValue;
			end
		end
	end

	// Read result and meter lookup are both held in flip-flops.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			readValue <= '0;
			lookupCir <= '0;
		end else begin
			if (opDone && opRead) begin
				readValue <= tableRead;
			end
			lookupCir <= (tbl.lookupEntry < CIR_COUNT) ?
				cir[tbl.lookupEntry] : '0;
		end
	end
endmodule // sip_meter_table

// ---- verification/sip_policy_regs_tb.sv ----
// Self-checking bench for the ingress policy register bank.
module sip_policy_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sip_pkg::*;
	// Bench drive signals, all given a value at time zero.
	logic                  clk_sys = 1'b0;
	logic                  rst = 1'b1;
	logic                  psel = 1'b0;
	logic                  penable = 1'b0;
	logic                  pwrite = 1'b0;
	logic [15:0]           paddr = 16'h0000;
	logic [31:0]           pwdata = 32'h0;
	logic [3:0]            pstrb = 4'hF;
	logic [1:0]            meterPort = 2'h0;
	logic [2:0]            meterPriority = 3'h0;
	// Design outputs.
	logic [31:0]           prdata, q;
	logic                  pready, pslverr, e, tick, meterEnable, meterValid;
	logic [2:0]            tagDestEnable, admitNonMember, bcastThrottleEnable;
	logic [2:0][13:0]      bcastByteBudget;
	sip_mode_t             meterMode;
	logic [20:0]           meterByteTimeNs;
	logic [15:0]           committedBurst, excessBurst;
	// Reference model state, kept as plain integers.
	int n_fail = 0, tests_run = 0, seed = 37, rv, ent, md, cbs, ebs;
	int cirM[24];
	int mdl[6] = '{0, 32'h0080402, 0, 0, 0, 0};
	localparam int MSK[4] = '{32'h3F, 32'h7FFFFFF, 32'h7, 32'h7};

	// Free-running 125 MHz clock.
	always #4 clk_sys = ~clk_sys;

	// A short tick interval keeps the run small.
	sip_policy_regs #(.THR_INTERVAL_CYCLES(16), .OP_CYCLES(2)) DUT (
		.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tagDestEnable(tagDestEnable), .admitNonMember(admitNonMember),
		.bcastThrottleEnable(bcastThrottleEnable),
		.bcastByteBudget(bcastByteBudget), .bcastIntervalTick(tick),
		.meterPort(meterPort), .meterPriority(meterPriority),
		.meterEnable(meterEnable), .meterMode(meterMode),
		.meterValid(meterValid), .meterByteTimeNs(meterByteTimeNs),
		.committedBurst(committedBurst), .excessBurst(excessBurst));

	// Verdict and end of run, also reached when a wait runs out.
	task automatic tally_and_finish();
		if (n_fail == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Compares a seen value with the model's value.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; the request stays up so a next one may follow.
	task automatic apb(input logic w, input logic [15:0] idx,
		input logic [31:0] d);
		int i;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx[13:0], 2'b00};
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clk_sys);
			if (pready === 1'b1) break;
		end
		q = prdata;
		e = pslverr;
		if (i == 16) begin
			n_fail++;
			tally_and_finish();
		end
	endtask

	// Drops the bus for one cycle so no access repeats.
	task automatic idle();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	// Polls the pending flag under a bound, as software must.
	task automatic wait_done();
		int i;
		for (i = 0; i < 20; i++) begin
			apb(1'b0, IDX_CMD_STATUS, 32'h0);
			if (q[0] === 1'b0) break;
		end
		chk(q, 32'h0);
	endtask

	// Main sequence.
	initial begin
		cbs = 16'h0600;
		ebs = 16'h0600;
		foreach (cirM[k]) cirM[k] = 16'h0014;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		// Reset values of the control registers.
		for (int k = 0; k < 6; k++) begin
			apb(1'b0, IDX_TAG_DEST + 16'(k), 32'h0);
			chk(q, mdl[k]);
		end
		// Random writes, read back and decoded at the ports.
		repeat (6) begin
			for (int k = 0; k < 4; k++) begin
				rv = $random(seed);
				apb(1'b1, IDX_TAG_DEST + 16'(k), rv);
				mdl[k] = rv & MSK[k];
				apb(1'b0, IDX_TAG_DEST + 16'(k), 32'h0);
				chk(q, mdl[k]);
			end
			for (int p = 0; p < 3; p++) begin
				chk(tagDestEnable[p], ((mdl[0] >> 2 * p) & 3) == 3);
				chk(bcastThrottleEnable[p], (mdl[1] >> (9 * p + 8)) & 1);
				chk(bcastByteBudget[p], ((mdl[1] >> 9 * p) & 255) * 64);
				chk(admitNonMember[p], (mdl[2] >> p) & 1);
			end
			chk(meterEnable, mdl[3] & 1);
			chk(meterMode, (mdl[3] >> 1) & 3);
		end
		// An unmapped place must be refused with an error.
		apb(1'b1, 16'h184F, 32'hFFFFFFFF);
		chk(e, 1'b1);
		// Table write then read back, every type, top entry included.
		for (int tp = 0; tp < 4; tp++) begin
			for (int j = 0; j < 2; j++) begin
				ent = j ? (($random(seed) & 32'hFF) % 24) : 23;
				rv = $random(seed) & 32'hFFFF;
				apb(1'b1, IDX_WRITE_VAL, rv);
				apb(1'b1, IDX_METER_CMD, (tp << 5) | ent);
				apb(1'b0, IDX_CMD_STATUS, 32'h0);
				chk(q, 32'h1);
				wait_done();
				if (tp == 1) cirM[ent] = rv;
				if (tp == 2) cbs = rv;
				if (tp == 3) ebs = rv;
				apb(1'b1, IDX_METER_CMD, 32'h80 | (tp << 5) | ent);
				wait_done();
				apb(1'b0, IDX_READ_VAL, 32'h0);
				chk(q, tp == 0 ? 0 : tp == 1 ? cirM[ent] : tp == 2 ? cbs : ebs);
			end
		end
		chk(committedBurst, cbs);
		chk(excessBurst, ebs);
		// Lookups in every mode; case 4 leaves metering off.
		for (int m = 0; m < 5; m++) begin
			apb(1'b1, IDX_METER_CFG, m == 4 ? 0 : (m << 1) | 1);
			idle();
			repeat (6) begin
				rv = ($random(seed) & 32'hFF) % 3;
				md = $random(seed) & 7;
				meterPort <= 2'(rv);
				meterPriority <= 3'(md);
				// The third edge still shows the second edge's result.
				repeat (3) @(posedge clk_sys);
				ent = m == 0 ? rv * 8 + md : m == 1 ? rv : md;
				chk(meterValid, m < 3);
				if (m < 3) chk(meterByteTimeNs, (cirM[ent] + 1) * 20);
			end
		end
		// A command written while one runs is dropped whole.
		apb(1'b1, IDX_METER_CMD, 32'hA0);
		apb(1'b1, IDX_METER_CMD, 32'h00);
		wait_done();
		apb(1'b0, IDX_METER_CMD, 32'h0);
		chk(q, 32'hA0);
		apb(1'b0, IDX_READ_VAL, 32'h0);
		chk(q, cirM[0]);
		idle();
		// Interval ticks come one clock long and 16 clocks apart.
		rv = 0;
		md = 0;
		for (int c = 0; c < 48; c++) begin
			@(posedge clk_sys);
			if (tick === 1'b1) begin
				if (rv > 0) chk(c - md, 16);
				rv++;
				md = c;
			end
		end
		chk(rv >= 2, 1'b1);
		tally_and_finish();
	end
endmodule // sip_policy_regs_tb
